// File: rtl/pld_pkg.sv
package pld_pkg;
  // Shared logic input bus and product-term layout
  localparam int BUS_W = 73;
  localparam int N_PT = 179;
  localparam int PT_PRI = 0;
  localparam int PT_SEC = 24;
  localparam int PT_SRAM = 36;
  localparam int PT_CFG = 38;
  localparam int PT_JTAG = 39;
  localparam int PT_PER = 40;
  localparam int PT_GEN = 42;
  localparam int GEN_PT = 137;
  // Offsets inside the general array
  localparam int G_NAT_SECOND = 24;
  localparam int G_CLK = 56;
  localparam int G_PRE = 72;
  localparam int G_CLR = 88;
  localparam int G_ECS = 120;
  localparam int G_POOL = 123;
  // Product terms per select and per macrocell
  localparam int PRI_TERMS = 3;
  localparam int SRAM_TERMS = 2;
  localparam int NATIVE_FIRST = 3;
  localparam int NATIVE_SECOND = 4;
  localparam int BORROW_FIRST = 6;
  localparam int BORROW_SECOND_LO = 5;
  localparam int BORROW_SECOND_HI = 6;
  localparam int BORROW_W = 6;
  // Configuration space offsets
  localparam logic [7:0] OFS_PAGE = 8'hE0;
  localparam logic [7:0] OFS_OMC_FIRST = 8'h20;
  localparam logic [7:0] OFS_OMC_SECOND = 8'h21;
  localparam logic [7:0] OFS_IMC_A = 8'h30;
  localparam logic [7:0] OFS_IMC_B = 8'h31;
  localparam logic [7:0] OFS_IMC_C = 8'h32;
  localparam logic [7:0] OFS_PWR0 = 8'hB0;
  localparam logic [7:0] OFS_PWR2 = 8'hB4;
  localparam logic [7:0] CFG_PAGE_DEF = 8'hFF;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] PWR0_RST = 8'h08;
  localparam logic [4:0] PWR2_RST = 5'h00;
  localparam int FAST_BIT = 3;
  // Standby timing
  localparam int CLK_NS = 10;
  localparam int STANDBY_NS = 70;
  localparam int STANDBY_CYC = (STANDBY_NS + CLK_NS - 1) / CLK_NS;
  // Macrocell configuration word and loader addresses
  localparam int MC_POL = 0;
  localparam int MC_REG = 1;
  localparam int MC_TYPE = 2;
  localparam int MC_CLKPIN = 4;
  localparam int MC_ROUTE = 5;
  localparam int MC_BORROW = 6;
  localparam int MC_CFG_W = 12;
  localparam logic [7:0] MC_CFG_BASE = 8'hC0;
  localparam int CFG_DATA_W = 2 * BUS_W;
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_type_t;
endpackage : pld_pkg

// File: rtl/page_reg_and_pld_macrocells.sv
`timescale 1ns/100ps
// Overview of operation
// [R1] Eight-bit paging register, host write and read
// [R2] Paging bits feed the decode array
// [R3] Paging register lives at config offset E0h
// [R4] Paging bits also reach general logic array
// [R5] Fast bit clear: standby after 70ns quiet
// [R6] Five power bits block host control signals
// [R7] Shared input bus carries 73 signals
// [R8] Eight primary, four secondary selects, three terms
// [R9] SRAM two terms, config, JTAG, two peripheral
// [R10] Three external chip selects, no macrocell used
// [R11] 24 inputs, 16 outputs, 137 product terms
// [R12] Host loads outputs, reads inputs and outputs
// [R13] Groups route to ports A/B and B/C
// [R14] XOR stage sets sum polarity
// [R15] Registered or combinational output, fed back
// [R16] Flip-flop acts as D, T, JK or SR
// [R17] Clock from product term or pin rise
// [R18] Active-high preset, clear of two terms
// [R19] Native and borrowable terms per macrocell group
// [R20] Data bit n maps to macrocell n
// [R21] Paging register clears to zero on reset
module page_reg_and_pld_macrocells (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Host register access
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata_r,
  // Logic inputs
  input wire logic [2:0] host_cntl,
  input wire logic power_down_input,
  input wire logic [2:0] port_d_in,
  input wire logic [23:0] port_abc_in,
  input wire logic sec_ready,
  // Array programming
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [pld_pkg::CFG_DATA_W-1:0] cfg_data,
  // Decode selects
  output logic [7:0] primary_sector_selects_r,
  output logic [3:0] secondary_sector_selects_r,
  output logic sram_select_r,
  output logic config_space_select_r,
  output logic jtag_select_r,
  output logic [1:0] periph_selects_r,
  // General array outputs
  output logic [2:0] external_chip_selects_r,
  output logic [7:0] paging_bits_r,
  output logic [7:0] port_a_out_r,
  output logic [7:0] port_a_oe_n_r,
  output logic [7:0] port_b_out_r,
  output logic [7:0] port_b_oe_n_r,
  output logic [7:0] port_c_out_r,
  output logic [7:0] port_c_oe_n_r,
  output logic standby_r
);
  import pld_pkg::*;

  logic [BUS_W-1:0] bus;
  logic [BUS_W-1:0] bus_prev_r;
  logic [N_PT-1:0] pt;
  logic [N_PT-1:0] pt_valid_r;
  logic [BUS_W-1:0] t_mem [N_PT];
  logic [BUS_W-1:0] c_mem [N_PT];
  logic [MC_CFG_W-1:0] mc_cfg_r [16];
  logic [7:0] pwr0_r;
  logic [4:0] pwr2_r;
  logic [2:0] quiet_cnt_r;
  logic [15:0] mc_q;
  logic [15:0] mc_val;
  logic [15:0] route;
  logic [2:0] cntl_g;
  logic [2:0] pd_g;
  logic [7:0] ofs;
  logic cfg_hit;
  logic eval_en;
  logic changed;
  logic fast;
  logic logic_clock_pin;
  logic pin_prev_r;
  logic pin_rise;
  logic [7:0] pri_nxt;
  logic [3:0] sec_nxt;
  logic sram_nxt;
  logic [2:0] ecs_nxt;

  // Blocked control inputs read as zero so the array sees no toggling
  assign cntl_g = host_cntl & ~pwr2_r[2:0]; // [R6]
  assign pd_g = {port_d_in[2] & ~pwr2_r[4], port_d_in[1], port_d_in[0] & ~pwr2_r[3]}; // [R6]
  assign logic_clock_pin = port_d_in[1];

  // Input bus: address, control, reset, power-down, inputs, page, feedback, ready
  assign bus = {sec_ready, mc_val, paging_bits_r, pd_g, port_abc_in, power_down_input, rst, cntl_g,
                host_addr}; // [R7] [R2] [R4] [R11]

  // Product terms: true and complement masks, an all-zero entry is unused
  genvar p;
  generate
    for (p = 0; p < N_PT; p++) begin : g_pt
      assign pt[p] = pt_valid_r[p] & ~|(t_mem[p] & ~bus) & ~|(c_mem[p] & bus); // [R11]
    end
  endgenerate

  // Array programming, kept out of reset since it is a large store
  always_ff @(posedge sys_clk) begin
    if (cfg_we && cfg_addr < 8'(N_PT)) begin
      t_mem[cfg_addr] <= cfg_data[BUS_W-1:0];
      c_mem[cfg_addr] <= cfg_data[CFG_DATA_W-1:BUS_W];
    end
  end

  // Valid flags and macrocell configuration need a defined start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pt_valid_r <= '0;
      for (int i = 0; i < 16; i++) mc_cfg_r[i] <= '0;
    end else if (cfg_we) begin
      if (cfg_addr < 8'(N_PT)) pt_valid_r[cfg_addr] <= |cfg_data;
      if (cfg_addr[7:4] == MC_CFG_BASE[7:4]) mc_cfg_r[cfg_addr[3:0]] <= cfg_data[MC_CFG_W-1:0];
    end
  end

  // Config space falls back to a fixed page until its select term exists
  assign ofs = host_addr[7:0];
  assign cfg_hit = pt_valid_r[PT_CFG] ? pt[PT_CFG] : (host_addr[15:8] == CFG_PAGE_DEF);

  // Paging register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      paging_bits_r <= PAGE_RST; // [R21]
    end else if (host_wr && cfg_hit && ofs == OFS_PAGE) begin // [R3]
      paging_bits_r <= host_wdata; // [R1]
    end
  end

  // Power control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr0_r <= PWR0_RST;
      pwr2_r <= PWR2_RST;
    end else if (host_wr && cfg_hit) begin
      if (ofs == OFS_PWR0) pwr0_r <= host_wdata;
      if (ofs == OFS_PWR2) pwr2_r <= host_wdata[4:0];
    end
  end

  // Read-back answers one cycle after the strobe and then holds
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_rdata_r <= 8'h00;
    end else if (host_rd && cfg_hit) begin
      case (ofs)
        OFS_PAGE: host_rdata_r <= paging_bits_r; // [R1]
        OFS_OMC_FIRST: host_rdata_r <= mc_q[7:0]; // [R12] [R20]
        OFS_OMC_SECOND: host_rdata_r <= mc_q[15:8]; // [R12] [R20]
        OFS_IMC_A: host_rdata_r <= port_abc_in[7:0]; // [R12]
        OFS_IMC_B: host_rdata_r <= port_abc_in[15:8];
        OFS_IMC_C: host_rdata_r <= port_abc_in[23:16];
        OFS_PWR0: host_rdata_r <= pwr0_r;
        OFS_PWR2: host_rdata_r <= {3'h0, pwr2_r};
        default: host_rdata_r <= 8'h00;
      endcase
    end
  end

  // Standby: quiet bus for the set time with fast mode off.
  // Waking costs one cycle, which models the longer propagation delay.
  assign fast = pwr0_r[FAST_BIT];
  assign changed = bus != bus_prev_r;
  assign eval_en = ~standby_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_prev_r <= '0;
      quiet_cnt_r <= 3'h0;
      standby_r <= 1'b0;
    end else begin
      bus_prev_r <= bus;
      if (changed) quiet_cnt_r <= 3'h0;
      else if (quiet_cnt_r < 3'(STANDBY_CYC)) quiet_cnt_r <= quiet_cnt_r + 3'h1;
      standby_r <= ~fast & ~changed & (standby_r | (quiet_cnt_r >= 3'(STANDBY_CYC - 1))); // [R5]
    end
  end

  // Pin clock edge seen only on evaluating cycles
  assign pin_rise = logic_clock_pin & ~pin_prev_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) pin_prev_r <= 1'b0;
    else if (eval_en) pin_prev_r <= logic_clock_pin;
  end

  // Decode selects: OR of each select's product terms
  always_comb begin
    pri_nxt = '0;
    sec_nxt = '0;
    for (int k = 0; k < 8; k++) pri_nxt[k] = |pt[PT_PRI + PRI_TERMS * k +: PRI_TERMS]; // [R8]
    for (int k = 0; k < 4; k++) sec_nxt[k] = |pt[PT_SEC + PRI_TERMS * k +: PRI_TERMS]; // [R8]
  end

  // Two-term SRAM select and single-term chip selects, named so the checks can look back at them
  assign sram_nxt = |pt[PT_SRAM +: SRAM_TERMS]; // [R9]
  assign ecs_nxt = pt[PT_GEN + G_ECS +: 3]; // [R10]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      primary_sector_selects_r <= 8'h00;
      secondary_sector_selects_r <= 4'h0;
      sram_select_r <= 1'b0;
      config_space_select_r <= 1'b0;
      jtag_select_r <= 1'b0;
      periph_selects_r <= 2'h0;
      external_chip_selects_r <= 3'h0;
    end else if (eval_en) begin
      primary_sector_selects_r <= pri_nxt; // [R2]
      secondary_sector_selects_r <= sec_nxt;
      sram_select_r <= sram_nxt; // [R9]
      config_space_select_r <= cfg_hit; // [R9]
      jtag_select_r <= pt[PT_JTAG]; // [R9]
      periph_selects_r <= pt[PT_PER +: 2]; // [R9]
      external_chip_selects_r <= ecs_nxt; // [R10]
    end
  end

  // Output macrocells, first group 0-7, second group 8-15
  genvar n;
  generate
    for (n = 0; n < 16; n++) begin : g_mc
      localparam int M = n % 8;
      localparam int NAT = (n < 8) ? NATIVE_FIRST : NATIVE_SECOND;
      localparam int BASE = PT_GEN + ((n < 8) ? NATIVE_FIRST * M : G_NAT_SECOND + NATIVE_SECOND * M);
      localparam int LIM = (n < 8) ? BORROW_FIRST : ((M < 4) ? BORROW_SECOND_LO : BORROW_SECOND_HI);
      localparam logic [BORROW_W-1:0] LIM_MASK = BORROW_W'((1 << LIM) - 1);
      logic [MC_CFG_W-1:0] cfg;
      logic [NAT-1:0] native;
      logic borrowed;
      logic s;
      logic set_t;
      logic rst_t;
      logic tick;
      logic pre;
      logic clr;
      logic load;
      logic clk_pt_prev_r;
      logic comb_r;
      ff_type_t ty;
      assign cfg = mc_cfg_r[n];
      assign ty = ff_type_t'(cfg[MC_TYPE +: 2]);
      assign native = pt[BASE +: NAT]; // [R19]
      // Borrowing is capped by the group's limit on the shared pool
      assign borrowed = |(pt[PT_GEN + G_POOL +: BORROW_W] & cfg[MC_BORROW +: BORROW_W] & LIM_MASK); // [R19]
      assign s = (|native | borrowed) ^ cfg[MC_POL]; // [R14]
      assign set_t = (|native[NAT-2:0] | borrowed) ^ cfg[MC_POL];
      assign rst_t = native[NAT-1];
      assign tick = cfg[MC_CLKPIN] ? pin_rise : (pt[PT_GEN + G_CLK + n] & ~clk_pt_prev_r); // [R17]
      assign pre = pt[PT_GEN + G_PRE + n]; // [R18]
      assign clr = |pt[PT_GEN + G_CLR + 2 * n +: 2]; // [R18]
      assign load = host_wr & cfg_hit & (ofs == ((n < 8) ? OFS_OMC_FIRST : OFS_OMC_SECOND)); // [R12]

      // Host load beats clear, clear beats preset, preset beats clock
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          mc_q[n] <= 1'b0;
        end else if (load) begin
          mc_q[n] <= host_wdata[M]; // [R20]
        end else if (eval_en) begin
          if (clr) mc_q[n] <= 1'b0; // [R18]
          else if (pre) mc_q[n] <= 1'b1;
          else if (tick) begin
            case (ty) // [R16]
              FF_D: mc_q[n] <= s;
              FF_T: mc_q[n] <= mc_q[n] ^ s;
              FF_JK: mc_q[n] <= (set_t & ~mc_q[n]) | (~rst_t & mc_q[n]);
              FF_SR: mc_q[n] <= set_t | (~rst_t & mc_q[n]);
              default: mc_q[n] <= s;
            endcase
          end
        end
      end

      // Combinational path is sampled once to break the feedback loop
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          comb_r <= 1'b0;
          clk_pt_prev_r <= 1'b0;
        end else if (eval_en) begin
          comb_r <= s;
          clk_pt_prev_r <= pt[PT_GEN + G_CLK + n];
        end
      end

      assign mc_val[n] = cfg[MC_REG] ? mc_q[n] : comb_r; // [R15]
      assign route[n] = cfg[MC_ROUTE];
    end
  endgenerate

  // Pin routing: first group A or B, second group B or C; first wins on B
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_out_r <= 8'h00;
      port_a_oe_n_r <= 8'hFF;
      port_b_out_r <= 8'h00;
      port_b_oe_n_r <= 8'hFF;
      port_c_out_r <= 8'h00;
      port_c_oe_n_r <= 8'hFF;
    end else begin
      port_a_out_r <= mc_val[7:0]; // [R13]
      port_a_oe_n_r <= route[7:0];
      port_b_out_r <= (route[7:0] & mc_val[7:0]) | (~route[7:0] & mc_val[15:8]); // [R13]
      port_b_oe_n_r <= ~(route[7:0] | ~route[15:8]);
      port_c_out_r <= mc_val[15:8];
      port_c_oe_n_r <= ~route[15:8];
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_page_write: assert property ((host_wr && cfg_hit && ofs == OFS_PAGE)
    |=> paging_bits_r == $past(host_wdata)) else $error("page write lost"); // [R1] [R3]
  a_page_read: assert property ((host_rd && cfg_hit && ofs == OFS_PAGE && !host_wr)
    |=> host_rdata_r == $past(paging_bits_r)) else $error("page read wrong"); // [R1]
  a_page_reset: assert property ($past(rst) |-> paging_bits_r == PAGE_RST)
    else $error("page not cleared"); // [R21]
  a_standby_entry: assert property ((!fast && !changed)[*8] |-> standby_r)
    else $error("standby not entered"); // [R5]
  a_fast_awake: assert property (fast |=> !standby_r) else $error("standby in fast mode"); // [R5]
  a_ctrl_block: assert property (pwr2_r[0] |-> !bus[16]) else $error("control not blocked"); // [R6]
  a_sram_decode: assert property (eval_en |=> sram_select_r == $past(sram_nxt))
    else $error("sram select wrong"); // [R9] [R2]
  a_ecs_decode: assert property (eval_en |=> external_chip_selects_r == $past(ecs_nxt))
    else $error("chip select wrong"); // [R10]
  a_omc_load: assert property ((host_wr && cfg_hit && ofs == OFS_OMC_SECOND)
    |=> mc_q[15:8] == $past(host_wdata)) else $error("macrocell load wrong"); // [R12] [R20]
  a_clear_wins: assert property ((eval_en && g_mc[0].clr && !g_mc[0].load) |=> !mc_q[0])
    else $error("clear ignored"); // [R18]
  a_pin_clock: assert property ((eval_en && !g_mc[0].load && !g_mc[0].clr && !g_mc[0].pre
    && g_mc[0].cfg[MC_CLKPIN] && g_mc[0].ty == FF_D && pin_rise) |=> mc_q[0] == $past(g_mc[0].s))
    else $error("pin clock missed"); // [R17] [R16]
  a_port_a: assert property (!route[0] |=> port_a_out_r[0] == $past(mc_val[0]) && !port_a_oe_n_r[0])
    else $error("port A routing wrong"); // [R13] [R15]

  c_standby_wake: cover property (standby_r ##1 !standby_r);
  c_page_write: cover property (host_wr && cfg_hit && ofs == OFS_PAGE);
  c_omc_load: cover property (host_wr && cfg_hit && ofs == OFS_OMC_FIRST);
  c_pin_tick: cover property (eval_en && pin_rise && g_mc[0].cfg[MC_CLKPIN]);
endmodule : page_reg_and_pld_macrocells

// File: bench/host_bus_model.sv
`timescale 1ns/100ps
// Host side of the bus: one strobe per transfer, every change at the falling edge
module host_bus_model (
  // Clock
  input wire logic sys_clk,
  // Bus toward the device
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  // Answer from the device
  input wire logic [7:0] host_rdata_r
);
  // Idle bus from time zero so no device input starts unknown
  initial begin
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end

  // Write: strobe for one cycle, then park the address and scramble the data lines
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge sys_clk);
    host_wr = 1'b0;
    host_addr = 16'h0000;
    host_wdata = ~d;
  endtask : wr

  // Read: data is registered at the edge that takes the strobe and holds after
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
    host_addr = 16'h0000;
    @(negedge sys_clk);
    d = host_rdata_r;
  endtask : rd
endmodule : host_bus_model

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
  import pld_pkg::*;
  typedef struct packed {logic wr; logic [7:0] ofs; logic [7:0] data; logic [7:0] exp;} row_t;
  logic sys_clk;
  logic rst;
  logic [15:0] host_addr;
  logic [7:0] host_wdata;
  logic host_wr;
  logic host_rd;
  logic [7:0] host_rdata_r;
  logic [2:0] host_cntl;
  logic [23:0] port_abc_in;
  logic [2:0] port_d_in;
  logic cfg_we;
  logic [7:0] cfg_addr;
  logic [CFG_DATA_W-1:0] cfg_data;
  logic [7:0] pri_sel;
  logic [1:0] per_sel;
  logic [2:0] ecs;
  logic [7:0] page;
  logic [7:0] pa_out;
  logic [7:0] pb_out;
  logic standby;
  int err_count;
  int tests_run;
  // Register traffic with its expected readback; input macrocell rows do not write
  row_t rows [11] = '{'{1'b1, 8'hE0, 8'hA5, 8'hA5}, '{1'b1, 8'hE0, 8'hFF, 8'hFF},
    '{1'b1, 8'hE0, 8'h00, 8'h00}, '{1'b1, 8'hE0, 8'h5A, 8'h5A}, '{1'b1, 8'h20, 8'h96, 8'h96},
    '{1'b1, 8'h21, 8'h3C, 8'h3C}, '{1'b0, 8'h30, 8'h00, 8'h7E}, '{1'b0, 8'h31, 8'h00, 8'h81},
    '{1'b0, 8'h32, 8'h00, 8'hC3}, '{1'b1, 8'h55, 8'h77, 8'h00}, '{1'b1, 8'hB4, 8'hFF, 8'h1F}};

  host_bus_model u_host_bus_model (.sys_clk(sys_clk), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata_r(host_rdata_r));

  page_reg_and_pld_macrocells u_page_reg_and_pld_macrocells (.sys_clk(sys_clk), .rst(rst),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata_r(host_rdata_r), .host_cntl(host_cntl), .power_down_input(1'b0), .port_d_in(port_d_in),
    .port_abc_in(port_abc_in), .sec_ready(1'b0), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .primary_sector_selects_r(pri_sel), .secondary_sector_selects_r(), .sram_select_r(),
    .config_space_select_r(), .jtag_select_r(), .periph_selects_r(per_sel), .external_chip_selects_r(ecs),
    .paging_bits_r(page), .port_a_out_r(pa_out), .port_a_oe_n_r(), .port_b_out_r(pb_out),
    .port_b_oe_n_r(), .port_c_out_r(), .port_c_oe_n_r(), .standby_r(standby));

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host_bus_model.rd(a, v);
    chk8(what, exp, v);
  endtask : rdchk

  // Array programming pulse, one cycle per word
  task automatic prog(input logic [7:0] a, input logic [CFG_DATA_W-1:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_data = d;
    cfg_we = 1'b1;
    @(negedge sys_clk);
    cfg_we = 1'b0;
  endtask : prog

  task automatic finish_test;
    $display("Checks run %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // The whole sequence needs well under a thousand cycles; two thousand means a hang
  initial begin
    #20000;
    err_count++;
    finish_test();
  end

  // Main sequence, inputs change at the falling edge only
  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    host_cntl = 3'h0;
    port_abc_in = 24'hC3817E;
    port_d_in = 3'h0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_data = '0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk8("page after reset", 8'h00, page);
    chk1("standby after reset", 1'b0, standby);
    // Macrocells registered D type on the first port of their group, so loads hold
    for (int i = 0; i < 16; i++) begin
      prog(MC_CFG_BASE + 8'(i), 146'h2);
    end
    for (int i = 0; i < 11; i++) begin
      if (rows[i].wr) begin
        u_host_bus_model.wr({8'hFF, rows[i].ofs}, rows[i].data);
      end
      rdchk("row readback", {8'hFF, rows[i].ofs}, rows[i].exp);
    end
    chk8("paging bits", 8'h5A, page);
    chk8("port a pins", 8'h96, pa_out);
    chk8("port b pins", 8'h3C, pb_out);
    // A write outside the configuration space must not reach the paging register
    u_host_bus_model.wr(16'h00E0, 8'h33);
    repeat (2) @(negedge sys_clk);
    chk8("page after off-space write", 8'h5A, page);
    // Second reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk8("page after second reset", 8'h00, page);
    rdchk("power0 reset", 16'hFFB0, 8'h08);
    rdchk("power2 reset", 16'hFFB4, 8'h00);
    // Decode term on paging bit 0, chip select term on paging bit 1
    prog(8'(PT_PRI), 146'h1 << 48);
    prog(8'(PT_GEN + G_ECS), 146'h1 << 49);
    u_host_bus_model.wr(16'hFFE0, 8'h03);
    repeat (3) @(negedge sys_clk);
    chk1("primary select 0", 1'b1, pri_sel[0]);
    chk1("primary select 1", 1'b0, pri_sel[1]);
    chk1("chip select 0", 1'b1, ecs[0]);
    u_host_bus_model.wr(16'hFFE0, 8'h02);
    repeat (3) @(negedge sys_clk);
    chk1("primary select 0 off", 1'b0, pri_sel[0]);
    chk1("chip select 0 kept", 1'b1, ecs[0]);
    // Control line 0 feeds a peripheral select until power2 blocks it
    prog(8'(PT_PER), 146'h1 << 16);
    host_cntl = 3'h1;
    repeat (3) @(negedge sys_clk);
    chk1("periph select open", 1'b1, per_sel[0]);
    u_host_bus_model.wr(16'hFFB4, 8'h01);
    repeat (3) @(negedge sys_clk);
    chk1("periph select blocked", 1'b0, per_sel[0]);
    // Quiet inputs: no standby while fast mode is on, standby once it is off
    repeat (12) @(negedge sys_clk);
    chk1("standby in fast mode", 1'b0, standby);
    u_host_bus_model.wr(16'hFFB0, 8'h00);
    repeat (12) @(negedge sys_clk);
    chk1("standby when quiet", 1'b1, standby);
    port_abc_in = 24'h3C7E81;
    repeat (2) @(negedge sys_clk);
    chk1("wake on input change", 1'b0, standby);
    // Pin clock: macrocell 0 registered D on the pin, its sum term on input bit 0
    u_host_bus_model.wr(16'hFFB0, 8'h08);
    prog(MC_CFG_BASE, 146'h12);
    prog(8'(PT_GEN), 146'h1 << 21);
    repeat (3) @(negedge sys_clk);
    chk1("standby back in fast mode", 1'b0, standby);
    rdchk("macrocell before pin edge", 16'hFF20, 8'h00);
    port_d_in = 3'h2;
    repeat (3) @(negedge sys_clk);
    rdchk("macrocell after pin edge", 16'hFF20, 8'h01);
    chk1("pin clocked port a", 1'b1, pa_out[0]);
    // Clear term on the same input overrides the held value
    prog(8'(PT_GEN + G_CLR), 146'h1 << 21);
    repeat (3) @(negedge sys_clk);
    rdchk("macrocell after clear", 16'hFF20, 8'h00);
    finish_test();
  end
endmodule : tb
